// [hw/oscc_ctrl.sv]
// Oscillator select, switch sequencer, divisor registers and AXI4-Lite slave
// What this block does
// RULE1: Boot source taken from 3-bit strap field
// RULE2: Primary submode strap selects HS, XT, EC
// RULE3: Erased straps start in fast RC divide-by-N
// RULE4: Current source field read-only at 14:12
// RULE5: New source field at 10:8, boots from straps
// RULE6: Software avoids direct PLL to PLL switches
// RULE7: Lock bit plus permit strap freezes configuration
// RULE8: PLL lock status reads locked and enabled
// RULE9: Clock fail flag sets on failure, software clears
// RULE10: Bit 1 enables the secondary oscillator
// RULE11: Switch request bit clears when switch completes
// RULE12: Control writes need a preceding unlock sequence
// RULE13: Recover-on-interrupt clears doze enable
// RULE14: Doze ratio is two to the field power
// RULE15: Doze enable off forces one-to-one ratio
// RULE16: Fast RC postscaler 1 to 64, then 256
// RULE17: PLL output divider 2, 4, reserved, 8
// RULE18: PLL prescaler divides by field plus two
// RULE19: Feedback multiplier is field plus two, default 50
// RULE20: Unimplemented bits read zero, ignore writes
// RULE21: PLL factors give input times M over N1 N2
// RULE22: Cycle clock is oscillator divided by two
// RULE23: Wait ten new-source edges, then change over
// RULE24: Source multiplexer changes only while gated off
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module oscc_ctrl #(
  parameter int ADDR_W = 4
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  output var logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output var logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output var logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output var logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output var logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output var logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output var logic [31:0] S_AXI_RDATA,
  output var logic [1:0] S_AXI_RRESP,
  input wire logic [2:0] CFG_OSC_SEL,
  input wire logic [1:0] CFG_PRI_SUBMODE,
  input wire logic CFG_LOCK_PERMIT,
  input wire logic PLL_LOCK_IN,
  input wire logic CLK_FAIL_IN,
  input wire logic INT_REQ_IN,
  input wire logic [7:0] SRC_CLK_IN,
  output var oscc_pkg::oscc_src_t SYS_SRC_SEL,
  output var logic CLK_GATE_EN,
  output var logic PLL_ENABLE,
  output var logic SECONDARY_OSC_ENABLE,
  output var oscc_pkg::oscc_pri_t PRI_MODE,
  output var logic [3:0] FRC_DIV_LOG2,
  output var oscc_pkg::oscc_pll_t PLL_FACTORS,
  output var logic CPU_CLK_EN,
  output var logic PERIPH_CLK_EN,
  output var logic SWITCH_BUSY
);
  localparam int SYNC_W = 17;

  // Full-width match of one register offset, so aliases above the map are not decoded
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // Address decode shared by read and write paths
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return addr_is(a, oscc_pkg::OFS_OSC_CTRL) || addr_is(a, oscc_pkg::OFS_CLK_DIV) ||
           addr_is(a, oscc_pkg::OFS_PLL_FBD) || addr_is(a, oscc_pkg::OFS_UNLOCK);
  endfunction

  // Two-stage synchronisers for every strap, status and source clock pin; third stage for edge detection
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [8:0] edge3;
  always_ff @(posedge CLK) begin
    sync1 <= {CFG_OSC_SEL, CFG_PRI_SUBMODE, CFG_LOCK_PERMIT, PLL_LOCK_IN,
              CLK_FAIL_IN, INT_REQ_IN, SRC_CLK_IN};
    sync2 <= sync1;
    edge3 <= {sync2[9], sync2[7:0]};
  end

  logic pll_lock_s;
  logic int_s;
  logic fail_rise;
  logic [7:0] src_s;
  logic [7:0] src_d;
  assign pll_lock_s = sync2[10];
  assign int_s = sync2[8];
  assign fail_rise = sync2[9] && !edge3[8];
  assign src_s = sync2[7:0];
  assign src_d = edge3[7:0];

  // Registers
  oscc_pkg::oscc_state_t state;
  oscc_pkg::oscc_state_t next_state;
  oscc_pkg::oscc_cfg_t cfg;
  oscc_pkg::oscc_src_t cosc;
  oscc_pkg::oscc_src_t nosc;
  logic clk_lock;
  logic cf;
  logic secondary_osc_en;
  logic switch_request_bit;
  logic recover_on_interrupt;
  logic [2:0] doze;
  logic doze_en;
  logic [2:0] frcdiv;
  logic [1:0] post;
  logic [4:0] pre;
  logic [8:0] fbd;
  logic key1_seen;
  logic unlock_armed;
  logic [1:0] boot_cnt;
  logic [3:0] edge_cnt;

  // AXI write side holding registers
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [ADDR_W-1:0] wr_a4;
  logic do_write;
  logic wr_osc;
  logic wr_div;
  logic wr_fbd;
  logic wr_key;
  logic lo;
  logic hi;
  assign do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign wr_a4 = aw_addr;
  assign lo = w_strb[0];
  assign hi = w_strb[1];
  assign wr_osc = do_write && addr_is(wr_a4, oscc_pkg::OFS_OSC_CTRL) && unlock_armed; // RULE12
  assign wr_div = do_write && addr_is(wr_a4, oscc_pkg::OFS_CLK_DIV);
  assign wr_fbd = do_write && addr_is(wr_a4, oscc_pkg::OFS_PLL_FBD);
  assign wr_key = do_write && addr_is(wr_a4, oscc_pkg::OFS_UNLOCK);

  // Lock and switch qualifiers
  logic cfg_locked;
  logic idle;
  logic boot_done;
  logic forbidden;
  logic sw_req;
  logic sw_abort;
  logic sw_start;
  logic new_edge;
  logic switching;
  logic pll_in_use;
  logic lock_stat;
  assign cfg_locked = clk_lock && cfg.lock_permit; // RULE7
  assign idle = state == oscc_pkg::ST_IDLE;
  assign boot_done = state == oscc_pkg::ST_BOOT && boot_cnt == oscc_pkg::BOOT_WAIT;
  // PLL to PLL switches are refused as a safeguard
  assign forbidden = oscc_pkg::uses_pll(cosc) && oscc_pkg::uses_pll(nosc); // RULE6
  assign sw_req = idle && switch_request_bit;
  assign sw_abort = sw_req && (nosc == cosc || forbidden);
  assign sw_start = sw_req && !sw_abort;
  assign new_edge = src_s[nosc] && !src_d[nosc]; // RULE23
  assign switching = !(idle || state == oscc_pkg::ST_BOOT);
  assign pll_in_use = oscc_pkg::uses_pll(cosc) || (switching && oscc_pkg::uses_pll(nosc));
  assign lock_stat = pll_in_use && pll_lock_s; // RULE8

  // Next values of software-visible fields
  logic wd_lo;
  logic wd_hi;
  logic [1:0] wd_post;
  assign wd_lo = lo && !cfg_locked;
  assign wd_hi = hi && !cfg_locked;
  assign wd_post = w_data[oscc_pkg::POST_LSB +: 2];

  oscc_pkg::oscc_src_t next_nosc;
  logic next_clk_lock;
  logic next_cf;
  logic next_secondary_osc_en;
  logic next_switch_request_bit;
  logic next_doze_en;
  assign next_nosc = boot_done ? oscc_pkg::oscc_src_t'(sync2[16:14]) : // RULE1 RULE3 RULE5
    (wr_osc && wd_hi && idle) ?
      oscc_pkg::oscc_src_t'(w_data[oscc_pkg::NOSC_LSB +: 3]) : nosc;
  assign next_clk_lock = (wr_osc && wd_lo) ? w_data[oscc_pkg::CLOCK_LOCK_BIT_BIT] : clk_lock;
  assign next_secondary_osc_en = (wr_osc && lo) ? w_data[oscc_pkg::SECONDARY_OSC_EN_BIT] : secondary_osc_en; // RULE10
  // A failure seen in the clearing cycle still sets the flag
  assign next_cf = fail_rise ? 1'b1 : // RULE9
    ((wr_osc && lo && !w_data[oscc_pkg::CF_BIT]) || sw_start) ? 1'b0 : cf;
  assign next_switch_request_bit = (wr_osc && wd_lo && idle && w_data[oscc_pkg::SWITCH_REQUEST_BIT_BIT]) ? 1'b1 :
    (sw_abort || state == oscc_pkg::ST_CHANGE) ? 1'b0 : switch_request_bit; // RULE11
  assign next_doze_en = (recover_on_interrupt && int_s) ? 1'b0 : // RULE13
    (wr_div && hi) ? w_data[oscc_pkg::DOZE_ENABLE_BIT] : doze_en;

  // Switch sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      oscc_pkg::ST_BOOT: begin
        if (boot_done) begin
          next_state = oscc_pkg::ST_IDLE;
        end
      end
      oscc_pkg::ST_IDLE: begin
        if (sw_start) begin
          next_state = oscc_pkg::ST_WAIT_PLL;
        end
      end
      oscc_pkg::ST_WAIT_PLL: begin
        if (!oscc_pkg::uses_pll(nosc) || pll_lock_s) begin
          next_state = oscc_pkg::ST_COUNT;
        end
      end
      oscc_pkg::ST_COUNT: begin
        if (edge_cnt == oscc_pkg::SWITCH_WAIT_EDGES) begin // RULE23
          next_state = oscc_pkg::ST_GATE;
        end
      end
      oscc_pkg::ST_GATE: next_state = oscc_pkg::ST_CHANGE; // RULE24
      oscc_pkg::ST_CHANGE: next_state = oscc_pkg::ST_IDLE;
      default: next_state = oscc_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state, counters and straps
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= oscc_pkg::ST_BOOT;
      boot_cnt <= '0;
      edge_cnt <= '0;
      cfg <= '{oscc_pkg::SRC_FRC_DIVN, oscc_pkg::PRI_OFF, 1'b1};
      cosc <= oscc_pkg::SRC_FRC_DIVN; // RULE3
    end else begin
      state <= next_state;
      boot_cnt <= boot_cnt + {1'b0, state == oscc_pkg::ST_BOOT};
      edge_cnt <= (state == oscc_pkg::ST_COUNT) ? edge_cnt + {3'h0, new_edge} : '0;
      if (boot_done) begin
        cfg <= '{oscc_pkg::oscc_src_t'(sync2[16:14]), // RULE1
                 oscc_pkg::oscc_pri_t'(sync2[13:12]), sync2[11]}; // RULE2
        cosc <= oscc_pkg::oscc_src_t'(sync2[16:14]);
      end else if (state == oscc_pkg::ST_CHANGE) begin
        cosc <= nosc; // RULE4 RULE23
      end
    end
  end

  // Oscillator control and unlock registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      nosc <= oscc_pkg::SRC_FRC_DIVN;
      clk_lock <= 1'b0;
      cf <= 1'b0;
      secondary_osc_en <= 1'b0;
      switch_request_bit <= 1'b0;
      key1_seen <= 1'b0;
      unlock_armed <= 1'b0;
    end else begin
      nosc <= next_nosc;
      clk_lock <= next_clk_lock;
      cf <= next_cf;
      secondary_osc_en <= next_secondary_osc_en;
      switch_request_bit <= next_switch_request_bit;
      // Keys must be consecutive writes; any other write breaks or spends the unlock
      if (do_write) begin
        key1_seen <= wr_key && w_data[15:0] == oscc_pkg::UNLOCK_KEY1;
        unlock_armed <= wr_key && key1_seen && w_data[15:0] == oscc_pkg::UNLOCK_KEY2; // RULE12
      end
    end
  end

  // Clock divisor and PLL feedback registers; frozen fields under lock
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      recover_on_interrupt <= 1'b0;
      doze <= oscc_pkg::DOZE_RST; // RULE14
      doze_en <= 1'b0;
      frcdiv <= oscc_pkg::FRCDIV_RST; // RULE16
      post <= oscc_pkg::POST_RST; // RULE17
      pre <= oscc_pkg::PRE_RST; // RULE18
      fbd <= oscc_pkg::FBD_RST; // RULE19
    end else begin
      doze_en <= next_doze_en;
      if (wr_div && hi) begin
        recover_on_interrupt <= w_data[oscc_pkg::ROI_BIT];
        doze <= w_data[oscc_pkg::DOZE_LSB +: 3];
      end
      if (wr_div && !cfg_locked) begin // RULE7
        if (hi) frcdiv <= w_data[oscc_pkg::FRCDIV_LSB +: 3];
        if (lo && wd_post != oscc_pkg::POST_RSVD) post <= wd_post;
        if (lo) pre <= w_data[oscc_pkg::PRE_LSB +: 5];
      end
      if (wr_fbd && !cfg_locked) begin
        if (lo) fbd[7:0] <= w_data[7:0];
        if (hi) fbd[8] <= w_data[8];
      end
    end
  end

  // Read words; unimplemented bits tie to zero
  logic [15:0] osc_word;
  logic [15:0] div_word;
  logic [15:0] rd_word;
  assign osc_word = {1'b0, cosc, 1'b0, nosc, clk_lock, 1'b0, lock_stat, 1'b0, cf, // RULE20
                     1'b0, secondary_osc_en, switch_request_bit};
  assign div_word = {recover_on_interrupt, doze, doze_en, frcdiv, post, 1'b0, pre};
  assign rd_word = addr_is(S_AXI_ARADDR, oscc_pkg::OFS_OSC_CTRL) ? osc_word :
                   addr_is(S_AXI_ARADDR, oscc_pkg::OFS_CLK_DIV) ? div_word :
                   addr_is(S_AXI_ARADDR, oscc_pkg::OFS_PLL_FBD) ? {7'h00, fbd} : 16'h0000;

  // AXI4-Lite handshakes; one write and one read in flight
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= oscc_pkg::RESP_OKAY;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= oscc_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= addr_mapped(wr_a4) ? oscc_pkg::RESP_OKAY : oscc_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {16'h0000, rd_word};
        S_AXI_RRESP <= addr_mapped(S_AXI_ARADDR) ? oscc_pkg::RESP_OKAY :
                       oscc_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Cycle enable at half the oscillator rate, doze enable at or below it
  logic fcy_en;
  logic cpu_en;
  logic [3:0] doze_log2;
  assign doze_log2 = doze_en ? {1'b0, doze} : 4'h0; // RULE15
  oscc_div #(.CNT_W(8), .LOG_W(4)) u_fcy (
    .clk(CLK), .rst(SYS_RST), .tick(1'b1),
    .log2_ratio(oscc_pkg::FCY_LOG2), .pulse(fcy_en) // RULE22
  );
  oscc_div #(.CNT_W(8), .LOG_W(4)) u_doze (
    .clk(CLK), .rst(SYS_RST), .tick(fcy_en),
    .log2_ratio(doze_log2), .pulse(cpu_en) // RULE14
  );

  // Derived factors for the analog side
  oscc_pkg::oscc_pll_t pll_f;
  logic [3:0] frc_log2;
  logic gating;
  assign pll_f.mult = {1'b0, fbd} + oscc_pkg::FACTOR_OFS; // RULE19 RULE21
  assign pll_f.pre = {1'b0, pre} + oscc_pkg::FACTOR_OFS[5:0]; // RULE18
  assign pll_f.post = 4'h2 << (post[1] ? 2'h2 : {1'b0, post[0]}); // RULE17
  assign frc_log2 = (frcdiv == oscc_pkg::FRCDIV_MAX) ? oscc_pkg::FRCDIV_MAX_LOG2 :
                    {1'b0, frcdiv}; // RULE16
  // Gate stays shut until the selector has caught up with the new source
  assign gating = state inside {oscc_pkg::ST_GATE, oscc_pkg::ST_CHANGE} ||
                  SYS_SRC_SEL != cosc; // RULE24

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SYS_SRC_SEL <= oscc_pkg::SRC_FRC_DIVN;
      CLK_GATE_EN <= 1'b0;
      PLL_ENABLE <= 1'b0;
      SECONDARY_OSC_ENABLE <= 1'b0;
      PRI_MODE <= oscc_pkg::PRI_OFF;
      FRC_DIV_LOG2 <= '0;
      PLL_FACTORS <= '0;
      CPU_CLK_EN <= 1'b0;
      PERIPH_CLK_EN <= 1'b0;
      SWITCH_BUSY <= 1'b0;
    end else begin
      SYS_SRC_SEL <= (CLK_GATE_EN) ? SYS_SRC_SEL : cosc; // RULE24
      CLK_GATE_EN <= !gating && state != oscc_pkg::ST_BOOT;
      PLL_ENABLE <= pll_in_use;
      SECONDARY_OSC_ENABLE <= secondary_osc_en || cosc == oscc_pkg::SRC_SEC ||
                     (switching && nosc == oscc_pkg::SRC_SEC); // RULE10
      PRI_MODE <= cfg.pri; // RULE2
      FRC_DIV_LOG2 <= frc_log2;
      PLL_FACTORS <= pll_f;
      CPU_CLK_EN <= cpu_en;
      PERIPH_CLK_EN <= fcy_en;
      SWITCH_BUSY <= switching;
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_change;
    state == oscc_pkg::ST_CHANGE;
  endsequence
  property p_switch_done;
    s_change |=> !switch_request_bit && cosc == $past(nosc) && idle;
  endproperty
  a_switch_done: assert property (p_switch_done) else $error("switch did not complete"); // RULE11
  property p_redundant;
    sw_req && nosc == cosc |=> !switch_request_bit && cosc == $past(cosc);
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant switch kept"); // RULE23
  property p_cur_ro;
    $changed(cosc) |-> $past(state) inside {oscc_pkg::ST_CHANGE, oscc_pkg::ST_BOOT};
  endproperty
  a_cur_ro: assert property (p_cur_ro) else $error("current source moved"); // RULE4
  property p_locked;
    do_write && cfg_locked |=> $stable(nosc) && $stable(pre) && $stable(fbd);
  endproperty
  a_locked: assert property (p_locked) else $error("locked config changed"); // RULE7
  property p_unlock;
    do_write && !unlock_armed |=> $stable(nosc) && $stable(secondary_osc_en);
  endproperty
  a_unlock: assert property (p_unlock) else $error("write without unlock"); // RULE12
  property p_cf;
    fail_rise |=> cf;
  endproperty
  a_cf: assert property (p_cf) else $error("fail flag not set"); // RULE9
  property p_roi;
    recover_on_interrupt && int_s |=> !doze_en;
  endproperty
  a_roi: assert property (p_roi) else $error("interrupt left doze on"); // RULE13
  property p_fcy;
    PERIPH_CLK_EN |=> !PERIPH_CLK_EN ##1 PERIPH_CLK_EN;
  endproperty
  a_fcy: assert property (p_fcy) else $error("cycle enable not half rate"); // RULE22
  property p_nodoze;
    !doze_en && fcy_en |=> CPU_CLK_EN;
  endproperty
  a_nodoze: assert property (p_nodoze) else $error("doze off not one to one"); // RULE15
  property p_glitch;
    $changed(SYS_SRC_SEL) |-> !CLK_GATE_EN && !$past(CLK_GATE_EN);
  endproperty
  a_glitch: assert property (p_glitch) else $error("selector moved while gated on"); // RULE24
  property p_lockstat;
    S_AXI_ARVALID && S_AXI_ARREADY && addr_is(S_AXI_ARADDR, oscc_pkg::OFS_OSC_CTRL) &&
      !pll_in_use |=> !S_AXI_RDATA[oscc_pkg::LOCK_BIT];
  endproperty
  a_lockstat: assert property (p_lockstat) else $error("lock shown with PLL off"); // RULE8
endmodule // oscc_ctrl
`default_nettype wire

// [hw/oscc_pkg.sv]
// Package: register map, field layout, reset values and types of the clock control block
package oscc_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFS_CLK_DIV = 4'h4;
  localparam logic [3:0] OFS_PLL_FBD = 4'h8;
  localparam logic [3:0] OFS_UNLOCK = 4'hc;
  // Oscillator control field positions
  localparam int COSC_LSB = 12;
  localparam int NOSC_LSB = 8;
  localparam int CLOCK_LOCK_BIT_BIT = 7;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int SECONDARY_OSC_EN_BIT = 1;
  localparam int SWITCH_REQUEST_BIT_BIT = 0;
  // Clock divisor field positions
  localparam int ROI_BIT = 15;
  localparam int DOZE_LSB = 12;
  localparam int DOZE_ENABLE_BIT = 11;
  localparam int FRCDIV_LSB = 8;
  localparam int POST_LSB = 6;
  localparam int PRE_LSB = 0;
  // Reset values
  localparam logic [2:0] DOZE_RST = 3'h3;
  localparam logic [2:0] FRCDIV_RST = 3'h0;
  localparam logic [1:0] POST_RST = 2'h1;
  localparam logic [4:0] PRE_RST = 5'h00;
  localparam logic [8:0] FBD_RST = 9'h030;
  // Codes and keys
  localparam logic [1:0] POST_RSVD = 2'h2;
  localparam logic [2:0] FRCDIV_MAX = 3'h7;
  localparam logic [3:0] FRCDIV_MAX_LOG2 = 4'h8;
  localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
  localparam logic [15:0] UNLOCK_KEY2 = 16'h00aa;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing counts
  localparam logic [3:0] SWITCH_WAIT_EDGES = 4'ha;
  localparam logic [1:0] BOOT_WAIT = 2'h2;
  localparam logic [3:0] FCY_LOG2 = 4'h1;
  localparam logic [9:0] FACTOR_OFS = 10'h002;

  typedef enum logic [2:0] {
    SRC_FRC = 3'h0, SRC_FRC_PLL = 3'h1, SRC_PRI = 3'h2, SRC_PRI_PLL = 3'h3,
    SRC_SEC = 3'h4, SRC_LOW_POWER_RC_OSC = 3'h5, SRC_FRC_DIV16 = 3'h6, SRC_FRC_DIVN = 3'h7
  } oscc_src_t;

  typedef enum logic [1:0] {
    PRI_EC = 2'h0, PRI_XT = 2'h1, PRI_HS = 2'h2, PRI_OFF = 2'h3
  } oscc_pri_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0, ST_IDLE = 3'h1, ST_WAIT_PLL = 3'h2,
    ST_COUNT = 3'h3, ST_GATE = 3'h4, ST_CHANGE = 3'h5
  } oscc_state_t;

  // Strapped configuration caught after reset
  typedef struct packed {
    oscc_src_t src;
    oscc_pri_t pri;
    logic lock_permit;
  } oscc_cfg_t;

  // Division factors handed to the analog PLL
  typedef struct packed {
    logic [9:0] mult;
    logic [5:0] pre;
    logic [3:0] post;
  } oscc_pll_t;

  // True for the two sources that run through the PLL
  function automatic logic uses_pll(input oscc_src_t s);
    return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
  endfunction
endpackage

// [hw/oscc_div.sv]
// Power-of-two enable divider used for the cycle and doze clock enables
`timescale 1ns/1ps
`default_nettype none
module oscc_div #(
  parameter int CNT_W = 8,
  parameter int LOG_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [LOG_W-1:0] log2_ratio,
  output logic pulse
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] mask;

  // Low bits of the counter all ones marks every 2^n-th tick
  assign mask = (CNT_W'(1) << log2_ratio) - CNT_W'(1);
  assign pulse = tick && ((cnt & mask) == mask);

  // Counts input ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + CNT_W'(1);
    end
  end
endmodule // oscc_div
`default_nettype wire

// [test/test_oscillator_select_pll_divider_ctrl.sv]
// Self-checking testbench of the clock control block
`timescale 1ns/1ps
`default_nettype none
module test_oscillator_select_pll_divider_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic awr, wrdy, bv, arr, rv, gate, pll_en, secondary_osc, cpu_en, per_en, busy;
  logic [1:0] bresp, rresp;
  logic [2:0] cfg_sel = 3'h7;
  logic [1:0] cfg_sub = 2'h2;
  logic cfg_lp = 1'b1, pll_lk = 1'b1, cfail = 1'b0, irq = 1'b0;
  logic [7:0] src = 8'h00;
  logic [2:0] psel = 3'h7;
  logic [3:0] frc_log;
  logic [15:0] seed = 16'h085e;
  oscc_pkg::oscc_src_t sel;
  oscc_pkg::oscc_pri_t pri;
  oscc_pkg::oscc_pll_t fac;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int bad_count = 0;
  int samples_checked = 0;
  int n, cc, pc;
  localparam logic [1:0] OK = oscc_pkg::RESP_OKAY;

  oscc_ctrl #(.ADDR_W(5)) dut_u (.CLK(clk), .SYS_RST(rst),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .CFG_OSC_SEL(cfg_sel), .CFG_PRI_SUBMODE(cfg_sub), .CFG_LOCK_PERMIT(cfg_lp),
    .PLL_LOCK_IN(pll_lk), .CLK_FAIL_IN(cfail), .INT_REQ_IN(irq), .SRC_CLK_IN(src),
    .SYS_SRC_SEL(sel), .CLK_GATE_EN(gate), .PLL_ENABLE(pll_en), .SECONDARY_OSC_ENABLE(secondary_osc),
    .PRI_MODE(pri), .FRC_DIV_LOG2(frc_log), .PLL_FACTORS(fac), .CPU_CLK_EN(cpu_en),
    .PERIPH_CLK_EN(per_en), .SWITCH_BUSY(busy));

  // System clock, and source clocks running at half its rate
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) src <= ~src;

  task tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk_out(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_rd(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pseudo-random sequence for register values
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // AXI write: address and data offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    exp_b.push_back(er);
    awa <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv && k < 64);
    bry <= 1'b0;
    if (k >= 64) begin
      bad_count++;
      tally_and_finish;
    end
  endtask

  // AXI read with the expected word noted for the monitor
  task automatic rd(input logic [4:0] a, input logic [15:0] ed);
    int k;
    k = 0;
    @(posedge clk);
    exp_r.push_back({OK, 16'h0000, ed});
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arr) arv <= 1'b0;
    end while (!rv && k < 64);
    rry <= 1'b0;
    if (k >= 64) begin
      bad_count++;
      tally_and_finish;
    end
  endtask

  // Unlock keys, then the protected control write
  task automatic unl(input logic [15:0] d);
    wr(5'h0c, oscc_pkg::UNLOCK_KEY1, OK);
    wr(5'h0c, oscc_pkg::UNLOCK_KEY2, OK);
    wr(5'h00, d, OK);
  endtask

  // Counts processor and peripheral enables over 64 cycles
  task automatic cnt;
    cc = 0;
    pc = 0;
    repeat (64) begin
      @(posedge clk);
      cc += int'(cpu_en);
      pc += int'(per_en);
    end
  endtask

  // Waits for a switch to settle on the target source; a hang ends the run
  task automatic wait_sw(input oscc_pkg::oscc_src_t t);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((busy || sel !== t) && n < 400);
    chk_out({22'h0, n >= 400, 9'h0}, 32'h0);
    if (n >= 400) tally_and_finish;
  endtask

  // Monitor: responses against the oldest note, selector against the gate
  always @(posedge clk) begin
    if (rv && rry && exp_r.size() > 0) chk_rd({rresp, rdata}, exp_r.pop_front());
    if (bv && bry && exp_b.size() > 0) chk_out({30'h0, bresp}, {30'h0, exp_b.pop_front()});
    if (!rst && sel !== psel) chk_out({31'h0, gate}, 32'h0);
    psel <= sel;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    rd(5'h00, 16'h7700);
    chk_out({30'h0, pri}, {30'h0, oscc_pkg::PRI_HS});
    rd(5'h04, 16'h3040);
    rd(5'h08, 16'h0030);
    chk_out({12'h0, fac}, {12'h0, 10'd50, 6'd2, 4'd4});
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      wr(5'h08, seed, OK);
      rd(5'h08, {7'h00, seed[8:0]});
    end
    wr(5'h04, 16'hffff, OK);
    rd(5'h04, 16'hffdf);
    chk_out({12'h0, fac}, {12'h0, {1'b0, seed[8:0]} + 10'd2, 6'd33, 4'd8});
    chk_out({28'h0, frc_log}, 32'h8);
    wr(5'h04, 16'hff9f, OK);
    chk_out({28'h0, fac.post}, 32'h8);
    irq <= 1'b1;
    repeat (6) @(posedge clk);
    irq <= 1'b0;
    rd(5'h04, 16'hf7df);
    cnt;
    chk_out(cc, 32);
    chk_out(pc, 32);
    wr(5'h04, 16'h1840, OK);
    cnt;
    chk_out(32'(cc >= 15 && cc <= 17), 32'h1);
    irq <= 1'b1;
    repeat (6) @(posedge clk);
    irq <= 1'b0;
    rd(5'h04, 16'h1840);
    wr(5'h10, 16'h1234, oscc_pkg::RESP_SLVERR);
    wr(5'h00, 16'h0002, OK);
    rd(5'h00, 16'h7700);
    unl(16'h0002);
    rd(5'h00, 16'h7002);
    chk_out({31'h0, secondary_osc}, 32'h1);
    unl(16'h0003);
    wait_sw(oscc_pkg::SRC_FRC);
    rd(5'h00, 16'h0002);
    chk_out({30'h0, gate, pll_en}, 32'h2);
    cfail <= 1'b1;
    repeat (6) @(posedge clk);
    cfail <= 1'b0;
    rd(5'h00, 16'h000a);
    unl(16'h0002);
    rd(5'h00, 16'h0002);
    unl(16'h0103);
    wait_sw(oscc_pkg::SRC_FRC_PLL);
    rd(5'h00, 16'h1122);
    chk_out({30'h0, gate, pll_en}, 32'h3);
    unl(16'h0103);
    rd(5'h00, 16'h1122);
    unl(16'h0082);
    unl(16'h0102);
    rd(5'h00, 16'h10a2);
    wr(5'h08, 16'h0005, OK);
    rd(5'h08, {7'h00, seed[8:0]});
    tally_and_finish;
  end
endmodule // test_oscillator_select_pll_divider_ctrl
`default_nettype wire
